/* design/count_overflow_digit_mux.sv */
// overflow flag, digit multiplexer and zero blanking for a decimal counter
module count_overflow_digit_mux
    import count_readout_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic count_event_i,
    input wire logic counter_clear_n_i,
    input wire logic latch_strobe_n_i,
    input wire logic [SLOTS-1:0] slot_n_i,
    output logic overflow_n_o,
    output logic [BCD_W-1:0] bcd_n_o,
    output logic blank_o,
    output logic [SLOTS-1:0] slot_sel_o
);

    // pin synchronisers: first stage read only by the second
    logic event_s1_reg, event_s2_reg, event_prev_reg;
    logic clear_s1_n_reg, clear_s2_n_reg;
    logic strobe_s1_n_reg, strobe_s2_n_reg, strobe_prev_n_reg;
    logic [SLOTS-1:0] slot_s1_n_reg, slot_s2_n_reg;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_s1_reg <= PIN_IDLE;
            event_s2_reg <= PIN_IDLE;
            event_prev_reg <= PIN_IDLE;
            clear_s1_n_reg <= PIN_IDLE;
            clear_s2_n_reg <= PIN_IDLE;
            strobe_s1_n_reg <= PIN_IDLE;
            strobe_s2_n_reg <= PIN_IDLE;
            strobe_prev_n_reg <= PIN_IDLE;
            slot_s1_n_reg <= SLOT_IDLE_N;
            slot_s2_n_reg <= SLOT_IDLE_N;
        end else begin
            event_s1_reg <= count_event_i;
            event_s2_reg <= event_s1_reg;
            event_prev_reg <= event_s2_reg;
            clear_s1_n_reg <= counter_clear_n_i;
            clear_s2_n_reg <= clear_s1_n_reg;
            strobe_s1_n_reg <= latch_strobe_n_i;
            strobe_s2_n_reg <= strobe_s1_n_reg;
            strobe_prev_n_reg <= strobe_s2_n_reg;
            slot_s1_n_reg <= slot_n_i;
            slot_s2_n_reg <= slot_s1_n_reg;
        end
    end

    logic event_fall;
    logic strobe_fall;
    assign event_fall = event_prev_reg && !event_s2_reg;
    assign strobe_fall = strobe_prev_n_reg && !strobe_s2_n_reg;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // decade counter chain, counts on the falling edge of the event
    logic [DECADES-1:0][3:0] cnt_reg, cnt_next;
    logic [DECADES:0] carry;
    logic full_count;

    assign carry[0] = event_fall;

    genvar gd;
    generate
        for (gd = 0; gd < DECADES; gd++) begin : g_decade
            assign carry[gd+1] = carry[gd] && (cnt_reg[gd] == DIGIT_NINE);
            always_comb begin
                if (!clear_s2_n_reg) begin
                    cnt_next[gd] = DIGIT_ZERO;
                end else if (carry[gd]) begin
                    if (cnt_reg[gd] == DIGIT_NINE) begin
                        cnt_next[gd] = DIGIT_ZERO;
                    end else begin
                        cnt_next[gd] = cnt_reg[gd] + DIGIT_ONE;
                    end
                end else begin
                    cnt_next[gd] = cnt_reg[gd];
                end
            end

            a_digit_bcd: assert property (
                cnt_reg[gd] <= DIGIT_NINE)
                else $error("decade left the decimal range");
        end
    endgenerate

    // top decade rolling from nine to zero is the full-count edge
    // nine decades count but only the low eight are stored and shown
    assign full_count = carry[DECADES];

    // storage, capture flag and overflow flag
    logic [DIGITS-1:0][3:0] store_reg, store_next;
    logic capture_reg, capture_next;
    logic overflow_n_reg, overflow_n_next;

    always_comb begin
        store_next = store_reg;
        if (strobe_fall) begin
            store_next = cnt_reg[DIGITS-1:0];
        end
        capture_next = capture_reg;
        // clear beats a full count landing in the same cycle
        if (!clear_s2_n_reg) begin
            capture_next = 1'h0;
        end else if (full_count) begin
            capture_next = 1'h1;
        end
        overflow_n_next = overflow_n_reg;
        if (!strobe_s2_n_reg && capture_reg) begin
            overflow_n_next = 1'h0;
        end else if (strobe_s2_n_reg && !capture_reg) begin
            overflow_n_next = 1'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
            store_reg <= '0;
            capture_reg <= CAPTURE_RESET;
            overflow_n_reg <= OVERFLOW_N_RESET;
        end else begin
            cnt_reg <= cnt_next;
            store_reg <= store_next;
            capture_reg <= capture_next;
            overflow_n_reg <= overflow_n_next;
        end
    end

    // readout mux: slot index 0 is slot three, index 7 is slot ten
    logic [SLOTS-1:0] sel_next;
    logic [SLOTS-1:0][3:0] slot_bits;
    logic [3:0] bcd_or;
    logic [BCD_W-1:0] bcd_n_reg, bcd_n_next;
    logic [BLANK_SLOTS:0] zero_run;
    logic [BLANK_SLOTS-1:0] blank_hit;
    logic blank_reg, blank_next;
    logic [SLOTS-1:0] sel_reg;

    assign sel_next = ~slot_s2_n_reg;
    assign zero_run[0] = 1'h1;

    genvar gs;
    generate
        for (gs = 0; gs < SLOTS; gs++) begin : g_slot
            // slot ten lands on the least significant digit
            assign slot_bits[gs] = sel_next[gs] ?
                store_reg[DIGITS-1-gs] : DIGIT_ZERO;

            a_mux_slot: assert property (
                (slot_s2_n_reg == ~(SLOTS'(1) << gs))
                |=> (bcd_n_o == ~$past(store_reg[DIGITS-1-gs])))
                else $error("selected slot does not show its digit");

            if (gs < BLANK_SLOTS) begin : g_blank
                assign zero_run[gs+1] = zero_run[gs] &&
                    (store_reg[DIGITS-1-gs] == DIGIT_ZERO);
                assign blank_hit[gs] = sel_next[gs] && zero_run[gs+1];

                a_blank_nonzero: assert property (
                    (slot_s2_n_reg == ~(SLOTS'(1) << gs)) &&
                    (store_reg[DIGITS-1-gs] != DIGIT_ZERO) |=> !blank_o)
                    else $error("nonzero digit blanked");

                a_blank_lead: assert property (
                    (slot_s2_n_reg == ~(SLOTS'(1) << gs)) && overflow_n_reg &&
                    (store_reg[DIGITS-1:DIGITS-1-gs] == '0) |=> blank_o)
                    else $error("leading zero not blanked");
            end
        end
    endgenerate

    always_comb begin
        bcd_or = DIGIT_ZERO;
        for (int k = 0; k < SLOTS; k++) begin
            bcd_or = bcd_or | slot_bits[k];
        end
        // wired-or pull-up idles high; a stored one pulls the line low
        bcd_n_next = BCD_IDLE_N & ~bcd_or;
        // an overflowing count keeps all digits so nothing hides the MSD
        blank_next = (|blank_hit) && overflow_n_reg;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bcd_n_reg <= BCD_IDLE_N;
            blank_reg <= BLANK_RESET;
            sel_reg <= SEL_RESET;
        end else begin
            bcd_n_reg <= bcd_n_next;
            blank_reg <= blank_next;
            sel_reg <= sel_next;
        end
    end

    assign overflow_n_o = overflow_n_reg;
    assign bcd_n_o = bcd_n_reg;
    assign blank_o = blank_reg;
    assign slot_sel_o = sel_reg;

    a_capture_set: assert property (
        full_count && clear_s2_n_reg |=> capture_reg)
        else $error("capture flag not set by full count");

    a_full_wrap: assert property (
        event_fall && clear_s2_n_reg && (cnt_reg == {DECADES{DIGIT_NINE}})
        |=> (cnt_reg == '0) && capture_reg)
        else $error("count past all nines did not wrap and capture");

    a_capture_clear: assert property (
        !clear_s2_n_reg |=> !capture_reg)
        else $error("capture flag survived counter clear");

    a_overflow_show: assert property (
        !strobe_s2_n_reg && capture_reg |=> !overflow_n_o)
        else $error("overflow not shown on strobe with capture");

    a_overflow_idle: assert property (
        (!clear_s2_n_reg && strobe_s2_n_reg)[*2] |=> overflow_n_o)
        else $error("overflow not made inactive by clear");

    a_lines_idle: assert property (
        (slot_s2_n_reg == SLOT_IDLE_N) |=> (bcd_n_o == BCD_IDLE_N))
        else $error("bcd lines not idle high without select");

    a_slot_ten: assert property (
        (slot_s2_n_reg == 8'h7F) |=> (bcd_n_o == ~$past(store_reg[0])))
        else $error("slot ten does not show least digit inverted");

    a_sel_pulse: assert property (
        ##1 (slot_sel_o == ~$past(slot_s2_n_reg)))
        else $error("select output not inverse of slot pulse");

    a_blank_window: assert property (
        (slot_s2_n_reg[3:0] == 4'hF) |=> !blank_o)
        else $error("blank asserted outside slots three to six");

    a_latch_copy: assert property (
        strobe_fall |=> (store_reg == $past(cnt_reg[DIGITS-1:0])))
        else $error("storage did not copy counters on strobe");

    a_clear_zero: assert property (
        !clear_s2_n_reg |=> (cnt_reg == '0))
        else $error("counter clear left a decade nonzero");

    a_blank_overflow: assert property (
        !overflow_n_reg |=> !blank_o)
        else $error("blank asserted while overflow shown");

    a_capture_rise: assert property (
        $rose(capture_reg) |-> $past(full_count))
        else $error("capture flag set without a full count");

    a_capture_keep: assert property (
        capture_reg && clear_s2_n_reg |=> capture_reg)
        else $error("capture flag dropped without a clear");

    a_count_step: assert property (
        event_fall && clear_s2_n_reg && (cnt_reg[0] != DIGIT_NINE)
        |=> (cnt_reg[0] == $past(cnt_reg[0]) + DIGIT_ONE))
        else $error("least decade did not advance by one");

    a_count_hold: assert property (
        !event_fall && clear_s2_n_reg |=> $stable(cnt_reg))
        else $error("counters moved without an event");

    a_overflow_fall: assert property (
        $fell(overflow_n_o) |-> !$past(strobe_s2_n_reg) && $past(capture_reg))
        else $error("overflow shown without strobe and capture");

    a_overflow_keep: assert property (
        strobe_s2_n_reg && capture_reg |=> $stable(overflow_n_o))
        else $error("overflow changed while capture held");

    a_overflow_rise: assert property (
        $rose(overflow_n_o) |-> $past(strobe_s2_n_reg) && !$past(capture_reg))
        else $error("overflow released without clear and strobe");

    a_lines_select: assert property (
        (bcd_n_o != BCD_IDLE_N) |-> (slot_sel_o != SEL_RESET))
        else $error("bcd lines pulled low with no select");

    a_blank_select: assert property (
        blank_o |-> (slot_sel_o[BLANK_SLOTS-1:0] != '0))
        else $error("blank without a slot three to six select");

    a_store_hold: assert property (
        !strobe_fall |=> $stable(store_reg))
        else $error("storage changed without a strobe");

endmodule

/* design/count_readout_pkg.sv */
// constants shared by the counter readout overflow and digit mux stage
package count_readout_pkg;
    localparam int DECADES = 9;
    localparam int DIGITS = 8;
    localparam int BCD_W = 4;
    localparam int SLOTS = 8;
    localparam int BLANK_SLOTS = 4;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] DIGIT_NINE = 4'h9;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [3:0] BCD_IDLE_N = 4'hF;
    localparam logic PIN_IDLE = 1'h1;
    localparam logic CAPTURE_RESET = 1'h0;
    localparam logic OVERFLOW_N_RESET = 1'h1;
    localparam logic BLANK_RESET = 1'h0;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SLOT_IDLE_N = 8'hFF;
endpackage

/* tb/slot_source.sv */
// readout system model: one active-low time-slot pulse on request
module slot_source
    import count_readout_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [2:0] idx_i,
    output logic [SLOTS-1:0] slot_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial slot_n_o = SLOT_IDLE_N;
    // one slot at a time; overlapping slots are not a legal use
    always @(posedge sys_clk_i) begin
        slot_n_o <= go_i ? ~(SLOTS'(1) << idx_i) : SLOT_IDLE_N;
    end
endmodule

/* tb/count_overflow_digit_mux_bench.sv */
// bench for the overflow flag, digit mux and zero blanking stage
module count_overflow_digit_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import count_readout_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ev = 1'h1;
    logic clr_n = 1'h1;
    logic stb_n = 1'h1;
    logic go = 1'h0;
    logic [2:0] idx = 3'h0;
    logic [SLOTS-1:0] slot_n;
    logic ovf_n;
    logic [BCD_W-1:0] bcd_n;
    logic blank;
    logic [SLOTS-1:0] sel;
    int n_errors = 0;
    int num_checks = 0;

    slot_source slot_source_inst (.sys_clk_i(clk), .go_i(go), .idx_i(idx),
        .slot_n_o(slot_n));
    count_overflow_digit_mux count_overflow_digit_mux_inst (
        .sys_clk_i(clk), .reset_n_i(rst_n), .count_event_i(ev),
        .counter_clear_n_i(clr_n), .latch_strobe_n_i(stb_n),
        .slot_n_i(slot_n), .overflow_n_o(ovf_n), .bcd_n_o(bcd_n),
        .blank_o(blank), .slot_sel_o(sel));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // inputs move 1 ns after the edge, away from sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // clear and strobe stay high while events are counted; two cycles a
    // level is twice the one cycle the pin synchroniser needs to resolve it
    task automatic count(input int n);
        repeat (n) begin
            ev = 1'h0;
            cyc(2);
            ev = 1'h1;
            cyc(2);
        end
    endtask

    task automatic strobe();
        stb_n = 1'h0;
        cyc(4);
        stb_n = 1'h1;
        cyc(4);
    endtask

    task automatic clear();
        clr_n = 1'h0;
        cyc(5);
        check("overflow_n", {7'h00, ovf_n}, 8'h01);
        clr_n = 1'h1;
        cyc(4);
    endtask

    // walks all eight slots; slot index k carries stored digit 7-k
    task automatic show_all(input logic [DIGITS-1:0][3:0] dig);
        logic lead;
        logic exp_blank;
        logic [3:0] cur;
        lead = 1'h1;
        for (int k = 0; k < SLOTS; k++) begin
            cur = dig[DIGITS-1-k];
            lead = lead && (cur == DIGIT_ZERO);
            exp_blank = lead && (k < BLANK_SLOTS);
            go = 1'h1;
            idx = k[2:0];
            cyc(5);
            check("slot_sel", sel, 8'h01 << k);
            check("bcd_n", {4'h0, bcd_n}, {4'h0, ~cur});
            check("blank", {7'h00, blank}, {7'h00, exp_blank});
            go = 1'h0;
            cyc(5);
            check("bcd_idle", {4'h0, bcd_n}, 8'h0F);
            check("sel_idle", sel, 8'h00);
        end
    endtask

    // outputs straight after reset release
    task automatic test_reset();
        check("overflow_n", {7'h00, ovf_n}, 8'h01);
        check("bcd_n", {4'h0, bcd_n}, 8'h0F);
        check("blank", {7'h00, blank}, 8'h00);
        check("slot_sel", sel, 8'h00);
    endtask

    task automatic test_small_count();
        clear();
        count(3);
        strobe();
        show_all(32'h00000003);
    endtask

    // ten more events carry into the second decade
    task automatic test_carry();
        count(10);
        strobe();
        show_all(32'h00000013);
    endtask

    // clear must zero the decades so a fresh latch shows zeros
    task automatic test_clear();
        clear();
        strobe();
        show_all(32'h00000000);
    endtask

    // a nonzero fifth digit stops blanking at slot six
    task automatic test_blank_chain();
        count(10000);
        strobe();
        show_all(32'h00010000);
    endtask

    // stimulus runs about 40k cycles; this leaves a margin
    initial begin
        #400000;
        n_errors++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'h1;
        test_reset();
        test_small_count();
        test_carry();
        test_clear();
        test_blank_chain();
        summarize();
    end
endmodule
